// [hdl/alse_core.sv]
`timescale 1ns/1ps
`default_nettype none
module alse_core (
  input  wire logic                   MCLK_I,
  input  wire logic                   RST_I,
  input  wire logic                   START_I,
  input  wire alse_pkg::alse_req_s    REQ_I,
  input  wire logic [15:0]            EXTENSION_FETCH_WORD_I,
  input  wire logic [15:0]            BUS_RDATA_I,
  output logic                        BUSY_O,
  output logic                        DONE_O,
  output alse_pkg::alse_result_s      RESULT_O,
  output alse_pkg::alse_flags_s       FLAG_WORD_O,
  output logic [15:0]                 BUS_ADDR_O,
  output logic [15:0]                 BUS_WDATA_O,
  output logic [1:0]                  BUS_BE_O,
  output logic                        BUS_RD_O,
  output logic                        BUS_WR_O,
  output logic                        FETCH_O
);

  typedef enum {
    ALSE_SEQ_IDLE,
    ALSE_SEQ_EXT,
    ALSE_SEQ_RD,
    ALSE_SEQ_GAP,
    ALSE_SEQ_WR,
    ALSE_SEQ_FETCH
  } alse_state_e;

  alse_state_e            state_reg, state_next;
  alse_pkg::alse_req_s    req_reg, req_next, cur;
  alse_pkg::alse_flags_s  flags_reg, flags_next, alu_flags;
  alse_pkg::alse_result_s result_reg, result_next, alu_res;
  logic [15:0]            imm_reg, imm_next;
  logic [15:0]            rdata_reg, rdata_next;
  logic [15:0]            addr_reg, addr_next;
  logic [15:0]            wdata_reg, wdata_next;
  logic                   done_reg, done_next;
  logic                   exec_fire;
  logic [15:0]            src_opnd, dst_opnd, bsum_word;
  logic [16:0]            wsum;
  logic [8:0]             bsum;
  logic [3:0]             count_code;
  logic [31:0]            sh_data, sh_res, rnd_res;
  logic [4:0]             sh_count;
  logic                   sh_last, sh_sticky, rnd_inc;

  assign cur = (state_reg == ALSE_SEQ_IDLE) ? REQ_I : req_reg;

  // Operand selection.
  always_comb
  begin
    case (cur.src)
      alse_pkg::ALSE_SRC_IMM16:
        src_opnd = (state_reg == ALSE_SEQ_EXT) ? EXTENSION_FETCH_WORD_I
                                              : imm_reg;
      alse_pkg::ALSE_SRC_QUICK:
        src_opnd = {alse_pkg::QUICK_PAD,
                    cur.instr[alse_pkg::QUICK_MSB:alse_pkg::QUICK_LSB]};
      default:
        src_opnd = cur.src_val;
    endcase
    dst_opnd = cur.mem_dest ? rdata_reg : cur.dst_val;
  end

  // Shift count and shifter input.
  always_comb
  begin
    if (cur.src == alse_pkg::ALSE_SRC_QUICK)
    begin
      count_code = cur.instr[alse_pkg::QUICK_MSB:alse_pkg::QUICK_LSB];
    end
    else
    begin
      count_code = cur.src_val[alse_pkg::COUNT_MSB:0];
    end
    if (cur.op == alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT &&
        count_code == alse_pkg::COUNT_CODE_ZERO)
    begin
      sh_count = alse_pkg::COUNT_SIXTEEN;
    end
    else
    begin
      sh_count = {1'b0, count_code};
    end
    if (cur.size == alse_pkg::ALSE_SZ_LONG)
    begin
      sh_data = {cur.upper_word, dst_opnd};
    end
    else
    begin
      sh_data = {{16{dst_opnd[alse_pkg::WORD_MSB]}}, dst_opnd};
    end
  end

  alse_sra32 u_sra (
    .data_i     (sh_data),
    .count_i    (sh_count),
    .result_o   (sh_res),
    .last_out_o (sh_last),
    .sticky_o   (sh_sticky)
  );

  // Arithmetic and logic results with flags.
  always_comb
  begin
    bsum      = {1'b0, src_opnd[7:0]} + {1'b0, dst_opnd[7:0]};
    wsum      = {1'b0, src_opnd} + {1'b0, dst_opnd};
    bsum_word = 16'({{8{src_opnd[7]}}, src_opnd[7:0]} +
                    {{8{dst_opnd[7]}}, dst_opnd[7:0]});
    rnd_inc   = 1'b0;
    rnd_res   = sh_res;
    alu_res   = '{lo: alse_pkg::WORD_ZERO, hi: alse_pkg::WORD_ZERO,
                  lo_we: ~cur.mem_dest, hi_we: 1'b0};
    alu_flags = flags_reg;
    case (cur.op)
      alse_pkg::ALSE_OP_ADD, alse_pkg::ALSE_OP_ADD_QUICK:
      begin
        if (cur.size == alse_pkg::ALSE_SZ_BYTE)
        begin
          alu_res.lo  = {alse_pkg::UPPER_CARRY_PAD, bsum[8], bsum_word[7:0]};
          alu_flags.z = (bsum_word[7:0] == alse_pkg::UPPER_BYTE_ZERO);
          alu_flags.n = bsum_word[alse_pkg::BYTE_MSB];
          alu_flags.c = bsum[8];
          alu_flags.v = (src_opnd[7] == dst_opnd[7]) &&
                        (bsum_word[7] != src_opnd[7]);
        end
        else
        begin
          alu_res.lo  = wsum[15:0];
          alu_flags.z = (wsum[15:0] == alse_pkg::WORD_ZERO);
          alu_flags.n = wsum[alse_pkg::WORD_MSB];
          alu_flags.c = wsum[16];
          alu_flags.v = (src_opnd[15] == dst_opnd[15]) &&
                        (wsum[15] != src_opnd[15]);
        end
      end
      alse_pkg::ALSE_OP_AND:
      begin
        if (cur.size == alse_pkg::ALSE_SZ_BYTE)
        begin
          alu_res.lo  = {alse_pkg::UPPER_BYTE_ZERO,
                         src_opnd[7:0] & dst_opnd[7:0]};
          alu_flags.n = alu_res.lo[alse_pkg::BYTE_MSB];
        end
        else
        begin
          alu_res.lo  = src_opnd & dst_opnd;
          alu_flags.n = alu_res.lo[alse_pkg::WORD_MSB];
        end
        alu_flags.z = (alu_res.lo == alse_pkg::WORD_ZERO);
        alu_flags.v = 1'b0;
      end
      alse_pkg::ALSE_OP_ARITH_SHIFT_RIGHT,
      alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT:
      begin
        if (cur.op == alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT)
        begin
          rnd_inc = sh_sticky &&
                    ((cur.size == alse_pkg::ALSE_SZ_LONG) ?
                     sh_res[alse_pkg::LONG_MSB] : sh_res[alse_pkg::WORD_MSB]);
          rnd_res = sh_res + {31'h00000000, rnd_inc};
          // carry only on long all-ones round
          alu_flags.c = (cur.size == alse_pkg::ALSE_SZ_LONG) && rnd_inc &&
                        (sh_res == alse_pkg::ALL_ONES_LONG);
        end
        else
        begin
          alu_flags.c = sh_last;
        end
        alu_res.lo = rnd_res[15:0];
        alu_flags.v = 1'b0;
        if (cur.size == alse_pkg::ALSE_SZ_LONG)
        begin
          alu_res.hi    = rnd_res[31:16];
          alu_res.hi_we = 1'b1;
          alu_flags.z   = (rnd_res == alse_pkg::LONG_ZERO);
          alu_flags.n   = rnd_res[alse_pkg::LONG_MSB];
        end
        else
        begin
          alu_flags.z = (rnd_res[15:0] == alse_pkg::WORD_ZERO);
          alu_flags.n = rnd_res[alse_pkg::WORD_MSB];
        end
      end
      default:
      begin
        alu_res.lo_we = 1'b0;
      end
    endcase
  end

  // register forms finish in the start cycle or after extension
  assign exec_fire = ((state_reg == ALSE_SEQ_IDLE) && START_I &&
                      REQ_I.src != alse_pkg::ALSE_SRC_IMM16 &&
                      !REQ_I.mem_dest) ||
                     ((state_reg == ALSE_SEQ_EXT) && !req_reg.mem_dest) ||
                     (state_reg == ALSE_SEQ_GAP);

  // Sequencer and datapath registers.
  always_comb
  begin
    state_next  = state_reg;
    req_next    = req_reg;
    imm_next    = imm_reg;
    rdata_next  = rdata_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    flags_next  = flags_reg;
    result_next = result_reg;
    done_next   = 1'b0;
    if (exec_fire)
    begin
      flags_next  = alu_flags;
      result_next = alu_res;
      wdata_next  = alu_res.lo;
      done_next   = ~cur.mem_dest;
    end
    case (state_reg)
      ALSE_SEQ_IDLE:
      begin
        if (START_I)
        begin
          req_next  = REQ_I;
          addr_next = 16'(REQ_I.disp + REQ_I.base);
          if (REQ_I.src == alse_pkg::ALSE_SRC_IMM16)
          begin
            state_next = ALSE_SEQ_EXT;
          end
          else if (REQ_I.mem_dest)
          begin
            state_next = ALSE_SEQ_RD;
          end
        end
      end
      ALSE_SEQ_EXT:
      begin
        imm_next   = EXTENSION_FETCH_WORD_I;
        state_next = req_reg.mem_dest ? ALSE_SEQ_RD : ALSE_SEQ_IDLE;
      end
      ALSE_SEQ_RD:
      begin
        rdata_next = BUS_RDATA_I;
        state_next = ALSE_SEQ_GAP;
      end
      ALSE_SEQ_GAP:
      begin
        state_next = ALSE_SEQ_WR;
      end
      ALSE_SEQ_WR:
      begin
        state_next = ALSE_SEQ_FETCH;
      end
      ALSE_SEQ_FETCH:
      begin
        done_next  = 1'b1;
        state_next = ALSE_SEQ_IDLE;
      end
      default:
      begin
        state_next = ALSE_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      state_reg  <= ALSE_SEQ_IDLE;
      req_reg    <= '0;
      imm_reg    <= alse_pkg::WORD_ZERO;
      rdata_reg  <= alse_pkg::WORD_ZERO;
      addr_reg   <= alse_pkg::WORD_ZERO;
      wdata_reg  <= alse_pkg::WORD_ZERO;
      flags_reg  <= '0;
      result_reg <= '0;
      done_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      req_reg    <= req_next;
      imm_reg    <= imm_next;
      rdata_reg  <= rdata_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      flags_reg  <= flags_next;
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  assign BUSY_O      = (state_reg != ALSE_SEQ_IDLE);
  assign DONE_O      = done_reg;
  assign RESULT_O    = result_reg;
  assign FLAG_WORD_O = flags_reg;
  assign BUS_ADDR_O  = addr_reg;
  assign BUS_WDATA_O = wdata_reg;
  assign BUS_RD_O    = (state_reg == ALSE_SEQ_RD);
  assign BUS_WR_O    = (state_reg == ALSE_SEQ_WR);
  assign FETCH_O     = (state_reg == ALSE_SEQ_FETCH);
  // memory byte writes use the low lane only
  assign BUS_BE_O    = (req_reg.size == alse_pkg::ALSE_SZ_BYTE) ?
                       alse_pkg::BE_LOW_BYTE : alse_pkg::BE_FULL_WORD;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence s_gap;
    !BUS_RD_O && !BUS_WR_O && !FETCH_O;
  endsequence

  sequence s_write_back;
    BUS_WR_O && (BUS_ADDR_O == $past(BUS_ADDR_O, 2));
  endsequence

  quick_one_cycle_a: assert property (
    (!BUSY_O && START_I && REQ_I.op == alse_pkg::ALSE_OP_ADD_QUICK &&
     REQ_I.src == alse_pkg::ALSE_SRC_QUICK && !REQ_I.mem_dest) |=> DONE_O)
    else $error("quick add to register did not finish in one cycle");

  imm_two_cycle_a: assert property (
    (!BUSY_O && START_I && REQ_I.src == alse_pkg::ALSE_SRC_IMM16 &&
     !REQ_I.mem_dest) |=> !DONE_O ##1 DONE_O)
    else $error("immediate add did not take two cycles");

  rmw_sequence_a: assert property (
    BUS_RD_O |-> (BUS_ADDR_O == 16'(req_reg.disp + req_reg.base))
      ##1 s_gap ##1 s_write_back ##1 FETCH_O ##1 DONE_O)
    else $error("memory read-modify-write sequence broken");

  byte_lane_a: assert property (
    (BUS_WR_O && req_reg.size == alse_pkg::ALSE_SZ_BYTE) |->
      BUS_BE_O == alse_pkg::BE_LOW_BYTE && !RESULT_O.lo_we)
    else $error("byte memory write touched the upper lane");

  byte_add_upper_a: assert property (
    (DONE_O && req_reg.size == alse_pkg::ALSE_SZ_BYTE && !req_reg.mem_dest &&
     (req_reg.op == alse_pkg::ALSE_OP_ADD ||
      req_reg.op == alse_pkg::ALSE_OP_ADD_QUICK)) |->
      RESULT_O.lo[15:8] == {alse_pkg::UPPER_CARRY_PAD, FLAG_WORD_O.c})
    else $error("byte add upper byte does not follow carry");

  word_add_flags_a: assert property (
    (DONE_O && req_reg.size == alse_pkg::ALSE_SZ_WORD && !req_reg.mem_dest &&
     req_reg.op == alse_pkg::ALSE_OP_ADD) |->
      FLAG_WORD_O.z == (RESULT_O.lo == alse_pkg::WORD_ZERO) &&
      FLAG_WORD_O.n == RESULT_O.lo[alse_pkg::WORD_MSB])
    else $error("word add zero or negative flag wrong");

  and_flags_a: assert property (
    (DONE_O && req_reg.op == alse_pkg::ALSE_OP_AND) |->
      !FLAG_WORD_O.v && FLAG_WORD_O.c == $past(FLAG_WORD_O.c))
    else $error("logical AND disturbed carry or overflow");

  and_byte_upper_a: assert property (
    (DONE_O && req_reg.op == alse_pkg::ALSE_OP_AND &&
     req_reg.size == alse_pkg::ALSE_SZ_BYTE) |->
      RESULT_O.lo[15:8] == alse_pkg::UPPER_BYTE_ZERO)
    else $error("byte AND upper byte not cleared");

  shift_zero_count_a: assert property (
    (DONE_O && req_reg.op == alse_pkg::ALSE_OP_ARITH_SHIFT_RIGHT &&
     req_reg.src == alse_pkg::ALSE_SRC_REG &&
     req_reg.src_val[alse_pkg::COUNT_MSB:0] == alse_pkg::COUNT_CODE_ZERO) |->
      !FLAG_WORD_O.c && !FLAG_WORD_O.v)
    else $error("zero register count left carry or overflow set");

  rounded_word_carry_a: assert property (
    (DONE_O && req_reg.op == alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT &&
     req_reg.size != alse_pkg::ALSE_SZ_LONG) |-> !FLAG_WORD_O.c)
    else $error("word rounded shift set carry");

endmodule : alse_core
`default_nettype wire

// [hdl/alse_pkg.sv]
`default_nettype none
package alse_pkg;

  localparam int unsigned BYTE_MSB    = 7;
  localparam int unsigned WORD_MSB    = 15;
  localparam int unsigned LONG_MSB    = 31;
  localparam int unsigned QUICK_LSB   = 4;
  localparam int unsigned QUICK_MSB   = 7;
  localparam int unsigned COUNT_MSB   = 3;

  localparam logic [7:0]  UPPER_BYTE_ZERO = 8'h00;
  localparam logic [6:0]  UPPER_CARRY_PAD = 7'h00;
  localparam logic [11:0] QUICK_PAD       = 12'h000;
  localparam logic [4:0]  COUNT_SIXTEEN   = 5'h10;
  localparam logic [3:0]  COUNT_CODE_ZERO = 4'h0;
  localparam logic [31:0] ALL_ONES_LONG   = 32'hFFFFFFFF;
  localparam logic [1:0]  BE_LOW_BYTE     = 2'h1;
  localparam logic [1:0]  BE_FULL_WORD    = 2'h3;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [31:0] LONG_ZERO       = 32'h00000000;

  typedef enum logic [2:0] {
    ALSE_OP_ADD,
    ALSE_OP_ADD_QUICK,
    ALSE_OP_AND,
    ALSE_OP_ARITH_SHIFT_RIGHT,
    ALSE_OP_ROUNDED_SHIFT_RIGHT
  } alse_op_e;

  typedef enum logic [1:0] {
    ALSE_SZ_BYTE,
    ALSE_SZ_WORD,
    ALSE_SZ_LONG
  } alse_size_e;

  typedef enum logic [1:0] {
    ALSE_SRC_REG,
    ALSE_SRC_IMM16,
    ALSE_SRC_QUICK
  } alse_src_e;

  typedef struct packed {
    alse_op_e   op;
    alse_size_e size;
    alse_src_e  src;
    logic       mem_dest;
    logic [15:0] instr;
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic [15:0] upper_word;
    logic [15:0] disp;
    logic [15:0] base;
  } alse_req_s;

  typedef struct packed {
    logic z;
    logic n;
    logic c;
    logic v;
  } alse_flags_s;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic        lo_we;
    logic        hi_we;
  } alse_result_s;

endpackage : alse_pkg
`default_nettype wire

// [hdl/alse_sra32.sv]
`timescale 1ns/1ps
`default_nettype none
module alse_sra32 (
  input  wire logic [31:0] data_i,
  input  wire logic [4:0]  count_i,
  output logic      [31:0] result_o,
  output logic             last_out_o,
  output logic             sticky_o
);

  logic [31:0] mask;

  // Sign bit is replicated into every vacated position.
  always_comb
  begin
    result_o   = 32'($signed(data_i) >>> count_i);
    mask       = ~(alse_pkg::ALL_ONES_LONG << count_i);
    sticky_o   = |(data_i & mask);
    last_out_o = 1'b0;
    if (count_i != 5'h00)
    begin
      last_out_o = data_i[5'(count_i - 5'h01)];
    end
  end

endmodule : alse_sra32
`default_nettype wire

// [verification/add_logic_shift_execute_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module add_logic_shift_execute_tb_top;
  logic                   mclk = 1'b0;
  logic                   rst = 1'b1;
  logic                   start = 1'b0;
  alse_pkg::alse_req_s    req = '0;
  logic [15:0]            ext = 16'h0000;
  logic [15:0]            rdata = 16'h0000;
  logic                   busy, done, rd, wr, fetch;
  alse_pkg::alse_result_s res;
  alse_pkg::alse_flags_s  flg;
  logic [15:0]            addr, wdata;
  logic [1:0]             be;
  logic [31:0]            seed = 32'h47A19C54;
  logic                   c_prev = 1'b0;
  int                     fail_count = 0;
  int                     n_compared = 0;

  always #10 mclk = ~mclk;

  alse_core i_dut (
    .MCLK_I                 (mclk),
    .RST_I                  (rst),
    .START_I                (start),
    .REQ_I                  (req),
    .EXTENSION_FETCH_WORD_I (ext),
    .BUS_RDATA_I            (rdata),
    .BUSY_O                 (busy),
    .DONE_O                 (done),
    .RESULT_O               (res),
    .FLAG_WORD_O            (flg),
    .BUS_ADDR_O             (addr),
    .BUS_WDATA_O            (wdata),
    .BUS_BE_O               (be),
    .BUS_RD_O               (rd),
    .BUS_WR_O               (wr),
    .FETCH_O                (fetch)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("Counts: %0d compared, %0d bad", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Reference result y and flags {z,n,c,v} for destination value d.
  task automatic model(input alse_pkg::alse_req_s r, input logic [15:0] d,
                       output logic [31:0] y, output logic [3:0] f);
    logic [15:0] s;
    logic [16:0] sum;
    logic [31:0] op, sh;
    logic [4:0]  n;
    logic        lng, bt, c, v, stk;
    lng = r.size == alse_pkg::ALSE_SZ_LONG;
    bt = r.size == alse_pkg::ALSE_SZ_BYTE;
    s = r.src == alse_pkg::ALSE_SRC_REG ? r.src_val :
        r.src == alse_pkg::ALSE_SRC_IMM16 ? ext : {12'h000, r.instr[7:4]};
    c = c_prev;
    v = 1'b0;
    if (r.op == alse_pkg::ALSE_OP_AND)
      y = bt ? {24'h000000, d[7:0] & s[7:0]} : {16'h0000, d & s};
    else if (r.op < alse_pkg::ALSE_OP_AND)
    begin
      sum = bt ? {9'h000, d[7:0]} + {9'h000, s[7:0]} : {1'b0, d} + {1'b0, s};
      c = bt ? sum[8] : sum[16];
      v = bt ? (d[7] == s[7]) && (sum[7] != d[7])
             : (d[15] == s[15]) && (sum[15] != d[15]);
      y = bt ? {23'h000000, c, sum[7:0]} : {16'h0000, sum[15:0]};
    end
    else
    begin
      n = {1'b0, s[3:0]};
      op = lng ? {r.upper_word, d} : {{16{d[15]}}, d};
      if (r.op == alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT && n == 5'h00)
        n = 5'h10;
      sh = $signed(op) >>> n;
      stk = |(op & ((32'h1 << n) - 32'h1));
      c = (n != 5'h00) ? op[n - 5'h01] : 1'b0;
      if (r.op == alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT)
      begin
        c = 1'b0;
        if (sh[31] && stk)
        begin
          c = lng && (sh == 32'hFFFFFFFF);
          sh = sh + 32'h1;
        end
      end
      y = sh;
    end
    f = {lng ? y == 32'h0 : bt ? y[7:0] == 8'h00 : y[15:0] == 16'h0000,
         lng ? y[31] : bt ? y[7] : y[15], c, v};
  endtask : model

  // Entered and left 2 ns after a rising edge.
  task automatic go(input alse_pkg::alse_op_e o, input alse_pkg::alse_size_e z,
                    input alse_pkg::alse_src_e sr, input logic m,
                    input logic [15:0] ins, input logic [15:0] sv,
                    input logic [15:0] dv, input logic [15:0] uw);
    logic [31:0] y, e;
    logic [3:0]  f;
    logic [7:0]  b;
    logic        bt;
    int          k, t_rd, t_wr, t_ft;
    seed = lfsr(seed);
    req = '{op: o, size: z, src: sr, mem_dest: m, instr: ins, src_val: sv,
            dst_val: dv, upper_word: uw, disp: seed[15:0], base: seed[31:16]};
    seed = lfsr(seed);
    ext = seed[15:0];
    rdata = seed[31:16];
    bt = z == alse_pkg::ALSE_SZ_BYTE;
    model(req, m ? rdata : dv, y, f);
    start = 1'b1;
    @(posedge mclk);
    #2;
    start = 1'b0;
    t_rd = 0;
    t_wr = 0;
    t_ft = 0;
    k = 1;
    while (done !== 1'b1 && k < 9)
    begin
      chk({31'h0, busy}, 32'h1);
      if (rd === 1'b1)
      begin
        t_rd = k;
        chk({16'h0000, addr}, {16'h0000, req.disp + req.base});
      end
      if (wr === 1'b1)
      begin
        t_wr = k;
        chk({16'h0000, addr}, {16'h0000, req.disp + req.base});
        chk({16'h0000, bt ? 8'h00 : wdata[15:8], wdata[7:0]},
            {16'h0000, bt ? 8'h00 : y[15:8], y[7:0]});
        chk({30'h0, be}, {30'h0, bt ? 2'h1 : 2'h3});
      end
      if (fetch === 1'b1)
        t_ft = k;
      @(posedge mclk);
      #2;
      k++;
    end
    chk({28'h0, busy, rd, wr, fetch}, 32'h0);
    b = (sr == alse_pkg::ALSE_SRC_IMM16) ? 8'h02 : 8'h01;
    e = m ? {b, b + 8'h02, b + 8'h03, b + 8'h04} : {24'h000000, b};
    chk({t_rd[7:0], t_wr[7:0], t_ft[7:0], k[7:0]}, e);
    chk({28'h0, flg}, {28'h0, f});
    chk({30'h0, res.lo_we, res.hi_we},
        {30'h0, !m, z == alse_pkg::ALSE_SZ_LONG});
    if (!m)
      chk({16'h0000, res.lo}, {16'h0000, y[15:0]});
    if (z == alse_pkg::ALSE_SZ_LONG)
      chk({16'h0000, res.hi}, {16'h0000, y[31:16]});
    c_prev = f[1];
    // One idle edge keeps the next request strobe apart from this one.
    @(posedge mclk);
    #2;
    chk({31'h0, done}, 32'h0);
  endtask : go

  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    alse_pkg::alse_op_e   o;
    alse_pkg::alse_size_e z;
    alse_pkg::alse_src_e  sr;
    logic                 shf;
    logic [31:0]          d;
    repeat (10) @(posedge mclk);
    #2;
    rst = 1'b0;
    chk({24'h0, busy, done, rd, wr, fetch, flg[3:1]}, 32'h0);
    chk({30'h0, be}, 32'h1);
    $display("test reset done");
    go(alse_pkg::ALSE_OP_ADD, alse_pkg::ALSE_SZ_BYTE, alse_pkg::ALSE_SRC_REG,
       1'b0, 16'h0000, 16'h0001, 16'h007F, 16'h0000);
    go(alse_pkg::ALSE_OP_ADD, alse_pkg::ALSE_SZ_BYTE, alse_pkg::ALSE_SRC_REG,
       1'b0, 16'h0000, 16'h0001, 16'h00FF, 16'h0000);
    go(alse_pkg::ALSE_OP_ADD, alse_pkg::ALSE_SZ_WORD, alse_pkg::ALSE_SRC_REG,
       1'b0, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000);
    go(alse_pkg::ALSE_OP_ADD_QUICK, alse_pkg::ALSE_SZ_BYTE,
       alse_pkg::ALSE_SRC_QUICK, 1'b0, 16'hFFF0, 16'hFFFF, 16'h00F5,
       16'h0000);
    go(alse_pkg::ALSE_OP_AND, alse_pkg::ALSE_SZ_BYTE, alse_pkg::ALSE_SRC_REG,
       1'b0, 16'h0000, 16'hFF80, 16'hFFC0, 16'h0000);
    go(alse_pkg::ALSE_OP_ADD, alse_pkg::ALSE_SZ_BYTE, alse_pkg::ALSE_SRC_IMM16,
       1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    go(alse_pkg::ALSE_OP_ARITH_SHIFT_RIGHT, alse_pkg::ALSE_SZ_WORD,
       alse_pkg::ALSE_SRC_REG, 1'b0, 16'h0000, 16'hFFF0, 16'h8001,
       16'h0000);
    go(alse_pkg::ALSE_OP_ARITH_SHIFT_RIGHT, alse_pkg::ALSE_SZ_LONG,
       alse_pkg::ALSE_SRC_QUICK, 1'b0, 16'h00F0, 16'h0000, 16'h0001,
       16'h8000);
    go(alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT, alse_pkg::ALSE_SZ_LONG,
       alse_pkg::ALSE_SRC_REG, 1'b0, 16'h0000, 16'hFFF4, 16'hFFFF,
       16'hFFFF);
    go(alse_pkg::ALSE_OP_ROUNDED_SHIFT_RIGHT, alse_pkg::ALSE_SZ_WORD,
       alse_pkg::ALSE_SRC_QUICK, 1'b0, 16'hFF0F, 16'h0000, 16'h8001,
       16'h0000);
    $display("test directed done");
    for (int i = 0; i < 200; i++)
    begin
      seed = lfsr(seed);
      o = alse_pkg::alse_op_e'(seed[2:0] % 3'h5);
      shf = o >= alse_pkg::ALSE_OP_ARITH_SHIFT_RIGHT;
      z = shf ? (seed[3] ? alse_pkg::ALSE_SZ_LONG : alse_pkg::ALSE_SZ_WORD)
              : (seed[3] ? alse_pkg::ALSE_SZ_BYTE : alse_pkg::ALSE_SZ_WORD);
      sr = o == alse_pkg::ALSE_OP_ADD_QUICK ? alse_pkg::ALSE_SRC_QUICK :
           !seed[4] ? alse_pkg::ALSE_SRC_REG :
           shf ? alse_pkg::ALSE_SRC_QUICK : alse_pkg::ALSE_SRC_IMM16;
      d = lfsr(seed);
      go(o, z, sr, !shf && seed[5], seed[31:16], d[15:0], d[31:16],
         seed[15:0]);
    end
    $display("test random done");
    finish_test();
  end
endmodule : add_logic_shift_execute_tb_top
`default_nettype wire
